// file: rtl/cmf_pkg.sv
package cmf_pkg;

   // register word offsets on the byte-addressed local port
   localparam logic [7:0] CMF_CTL_OFS   = 8'h00; // main_control_reg
   localparam logic [7:0] CMF_IER_OFS   = 8'h04; // mailbox_interrupt_enable
   localparam logic [7:0] CMF_TQC_OFS   = 8'h08; // tx_queue_control
   localparam logic [7:0] CMF_RQC_OFS   = 8'h0C; // rx_queue_control
   localparam logic [7:0] CMF_TQP_OFS   = 8'h10; // tx_queue_pointer_ctrl
   localparam logic [7:0] CMF_RQP_OFS   = 8'h14; // rx_queue_pointer_ctrl
   localparam logic [7:0] CMF_MSKA_OFS  = 8'h18; // queue_mask_a
   localparam logic [7:0] CMF_MSKB_OFS  = 8'h1C; // queue_mask_b
   localparam logic [7:0] CMF_CMPA_OFS  = 8'h20; // queue_id_compare_a
   localparam logic [7:0] CMF_CMPB_OFS  = 8'h24; // queue_id_compare_b
   localparam logic [7:0] CMF_SMOD_OFS  = 8'h28; // search mode
   localparam logic [7:0] CMF_SSTA_OFS  = 8'h2C; // search status
   localparam logic [7:0] CMF_CSRC_OFS  = 8'h30; // channel search value
   localparam logic [7:0] CMF_WID_OFS   = 8'h40; // window identifier
   localparam logic [7:0] CMF_WLO_OFS   = 8'h44; // window data low word
   localparam logic [7:0] CMF_WHI_OFS   = 8'h48; // window data high word
   localparam int         CMF_MCTL_BIT  = 7;     // address bit that selects mailbox controls

   // main_control_reg fields
   localparam int CMF_CTL_MBM = 0;   // mailbox_mode_select, 1 = queue mode
   localparam int CMF_CTL_MLM = 1;   // lost_mode_select, 1 = overrun

   // mailbox_control_reg fields
   localparam int CMF_MC_NEWD = 0;   // rx_complete_flag
   localparam int CMF_MC_LOST = 1;   // message_lost_flag
   localparam int CMF_MC_SENT = 2;   // tx_complete_flag
   localparam int CMF_MC_TABT = 3;   // tx_abort_done_flag
   localparam int CMF_MC_ONE  = 5;   // single_try_enable
   localparam int CMF_MC_RXS  = 6;   // rx_mailbox_set
   localparam int CMF_MC_TXS  = 7;   // tx_mailbox_set

   // queue control fields
   localparam int CMF_Q_EN    = 0;   // tx_queue_enable / rx_queue_enable
   localparam int CMF_TQ_EMP  = 1;   // tx_queue_empty
   localparam int CMF_TQ_FUL  = 2;   // tx_queue_full
   localparam int CMF_RQ_LOST = 1;   // rx_queue_lost_flag
   localparam int CMF_RQ_EMP  = 2;   // rx_queue_empty
   localparam int CMF_RQ_WRN  = 3;   // rx_queue_warning
   localparam int CMF_RQ_FUL  = 4;   // rx_queue_full

   // interrupt enable fields
   localparam int CMF_IE_TXQ  = 24;
   localparam int CMF_IE_TXM  = 25;
   localparam int CMF_IE_RXQ  = 28;
   localparam int CMF_IE_RXM  = 29;

   // mailbox map and queue sizes
   localparam logic [4:0] CMF_TXQ_MBX = 5'd24;
   localparam logic [4:0] CMF_RXQ_MBX = 5'd28;
   localparam logic [2:0] CMF_Q_DEPTH = 3'd4;
   localparam logic [2:0] CMF_Q_WARN  = 3'd3;
   localparam logic [7:0] CMF_PTR_ADV = 8'hFF;
   localparam int         CMF_SS_NONE = 7;   // search status: nothing found

   // search modes
   localparam logic [1:0] CMF_SM_RX   = 2'h0;
   localparam logic [1:0] CMF_SM_TX   = 2'h1;
   localparam logic [1:0] CMF_SM_LOST = 2'h2;
   localparam logic [1:0] CMF_SM_CHAN = 2'h3;

   typedef struct packed {
      logic [28:0] id;
      logic [63:0] data;
   } cmf_msg_t;

   typedef struct packed {
      logic [1:0]            ctl;
      logic [31:0]           ier;
      logic                  txen;
      logic                  rxen;
      logic                  rxlost;
      logic [1:0]            twp;
      logic [1:0]            trp;
      logic [1:0]            rwp;
      logic [1:0]            rrp;
      logic [2:0]            tc;
      logic [2:0]            rc;
      cmf_msg_t [3:0]        txq;
      cmf_msg_t [3:0]        rxq;
      logic [31:0][7:0]      mctl;
      logic [31:0]           abort;
      logic [28:0]           mska;
      logic [28:0]           mskb;
      logic [28:0]           cmpa;
      logic [28:0]           cmpb;
      logic [1:0]            smode;
      logic [7:0]            chan;
      logic [31:0]           rdata;
      logic                  txv;
      cmf_msg_t              txo;
      logic                  tirq;
      logic                  rirq;
   } cmf_state_t;

endpackage : cmf_pkg

// file: rtl/cmf_top.sv
// Behaviour
// - a one-shot mailbox holding a message takes nothing new until its flag clears.
// - clearing receive set, complete and lost flags in one write starts an abort.
// - a control bit picks normal mailbox mode or queue mailbox mode.
// - in queue mode 0-23 are normal, 24-27 transmit queue, 28-31 receive queue.
// - mailbox 24 is the transmit window, mailbox 28 the receive window.
// - writing FFh to a queue pointer register advances that queue's CPU pointer.
// - enable bit 24 gates transmit interrupt; bit 25 picks every or on empty.
// - bit 28 gates receive interrupt; bit 29 picks every or on reaching warning.
// - in queue mode mailbox controls 24-31 do nothing; queue controls rule.
// - the transmit queue works only while its enable bit is one.
// - disabling mid-transmission empties the queue at the next end event.
// - the transmit queue holds four; empty and full status bits report it.
// - the receive queue works only while its enable bit is one.
// - receive queue reports empty, warning at three, full at four.
// - arrival at a full receive queue sets lost; overrun drops, overwrite replaces.
// - receive queue stores only ids matching compare a/b under mask a/b.
// - transmit queue abort completes by setting the empty status bit.
// - in overrun mode the entry under the read pointer is never changed.
// - four search modes work in both mailbox modes.
// - in queue mode receive search reports 28 while the receive queue holds data and no mailbox 0-23 has new data.
`timescale 1ns/10ps
`default_nettype none
module cmf_top
   import cmf_pkg::*;
(
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   // register port
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   // receive side of the protocol engine
   input  wire logic        RX_VALID,
   input  wire cmf_msg_t    RX_MSG,
   input  wire logic        RX_MBX_HIT,
   input  wire logic [4:0]  RX_MBX,
   // transmit queue side of the protocol engine
   input  wire logic        TXQ_BUSY,
   input  wire logic        TXQ_DONE,
   input  wire logic        TXQ_FAIL,
   input  wire logic        HALT_ENTRY,
   output logic             TXQ_VALID,
   output cmf_msg_t         TXQ_MSG,
   // queue event pulses
   output logic             TXQ_IRQ,
   output logic             RXQ_IRQ
);

   cmf_state_t s_r;
   cmf_state_t s_nxt;
   logic       qmode;
   logic [4:0] wj;
   logic [7:0] wv;
   logic       norm_ok;
   logic       q_match;
   logic [5:0] srch;
   logic [31:0] cand;

   // lowest set bit, msb of result means something was found
   function automatic logic [5:0] cmf_lowest(input logic [31:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction : cmf_lowest

   // decode helpers shared by logic and checks
   assign qmode   = s_r.ctl[CMF_CTL_MBM];
   assign wj      = ADDR[6:2];
   assign wv      = WDATA[7:0];
   // a queue-mode mailbox 24..31 is never a normal target
   assign norm_ok = RX_VALID && RX_MBX_HIT && !(qmode && RX_MBX[4:3] == 2'b11)
                    && s_r.mctl[RX_MBX][CMF_MC_RXS] && !s_r.abort[RX_MBX];
   // mask bit one means the id bit is compared
   assign q_match = ((((RX_MSG.id ^ s_r.cmpa) & s_r.mska) == 29'h0) ||
                     (((RX_MSG.id ^ s_r.cmpb) & s_r.mskb) == 29'h0));

   // search candidates: in queue mode mailboxes 24-31 dropped, receive queue folded onto 28 in receive and lost search
   always_comb begin
      cand = 32'h0;
      case (s_r.smode)
         CMF_SM_RX: begin
            for (int i = 0; i < 32; i++) begin
               cand[i] = s_r.mctl[i][CMF_MC_NEWD];
            end
            if (qmode) begin
               cand[31:24] = 8'h00;
               cand[CMF_RXQ_MBX] = (s_r.rc != 3'h0);
            end
         end
         CMF_SM_TX: begin
            for (int i = 0; i < 32; i++) begin
               cand[i] = s_r.mctl[i][CMF_MC_SENT];
            end
            if (qmode) begin
               cand[31:24] = 8'h00;
            end
         end
         CMF_SM_LOST: begin
            for (int i = 0; i < 32; i++) begin
               cand[i] = s_r.mctl[i][CMF_MC_LOST];
            end
            if (qmode) begin
               cand[31:24] = 8'h00;
               cand[CMF_RXQ_MBX] = s_r.rxlost;
            end
         end
         default: begin
            cand = {24'h0, s_r.chan};
         end
      endcase
      srch = cmf_lowest(cand);
   end

   // next state: bus access first, hardware events after so sets win
   always_comb begin
      s_nxt      = s_r;
      s_nxt.tirq = 1'b0;
      s_nxt.rirq = 1'b0;

      // pending receive aborts finish one cycle after they start
      for (int j = 0; j < 32; j++) begin
         if (s_r.abort[j]) begin
            s_nxt.abort[j]               = 1'b0;
            s_nxt.mctl[j][CMF_MC_RXS]    = 1'b0;
         end
      end

      // register read, data appear in the next cycle only
      s_nxt.rdata = 32'h0;
      if (RD) begin
         case (ADDR)
            CMF_CTL_OFS:  s_nxt.rdata = {30'h0, s_r.ctl};
            CMF_IER_OFS:  s_nxt.rdata = s_r.ier;
            CMF_TQC_OFS:  s_nxt.rdata = {29'h0, s_r.tc == CMF_Q_DEPTH,
                                         s_r.tc == 3'h0, s_r.txen};
            CMF_RQC_OFS:  s_nxt.rdata = {27'h0, s_r.rc == CMF_Q_DEPTH,
                                         s_r.rc == CMF_Q_WARN, s_r.rc == 3'h0,
                                         s_r.rxlost, s_r.rxen};
            CMF_MSKA_OFS: s_nxt.rdata = {3'h0, s_r.mska};
            CMF_MSKB_OFS: s_nxt.rdata = {3'h0, s_r.mskb};
            CMF_CMPA_OFS: s_nxt.rdata = {3'h0, s_r.cmpa};
            CMF_CMPB_OFS: s_nxt.rdata = {3'h0, s_r.cmpb};
            CMF_SMOD_OFS: s_nxt.rdata = {30'h0, s_r.smode};
            CMF_SSTA_OFS: begin
               s_nxt.rdata = {24'h0, !srch[5], 2'h0, srch[4:0]};
               // channel search moves on to the next channel once read
               if (s_r.smode == CMF_SM_CHAN && srch[5]) begin
                  s_nxt.chan[srch[2:0]] = 1'b0;
               end
            end
            CMF_CSRC_OFS: s_nxt.rdata = {24'h0, s_r.chan};
            // the receive window shows the entry under the read pointer
            CMF_WID_OFS:  s_nxt.rdata = qmode ? {3'h0, s_r.rxq[s_r.rrp].id} : 32'h0;
            CMF_WLO_OFS:  s_nxt.rdata = qmode ? s_r.rxq[s_r.rrp].data[31:0] : 32'h0;
            CMF_WHI_OFS:  s_nxt.rdata = qmode ? s_r.rxq[s_r.rrp].data[63:32] : 32'h0;
            default: begin
               if (ADDR[CMF_MCTL_BIT] && !(qmode && wj[4:3] == 2'b11)) begin
                  s_nxt.rdata = {24'h0, s_r.mctl[wj]};
               end
            end
         endcase
      end

      // register write
      if (WR) begin
         case (ADDR)
            CMF_CTL_OFS:  s_nxt.ctl = WDATA[1:0];
            CMF_IER_OFS:  s_nxt.ier = WDATA;
            CMF_TQC_OFS:  s_nxt.txen = WDATA[CMF_Q_EN];
            CMF_RQC_OFS: begin
               s_nxt.rxen = WDATA[CMF_Q_EN];
               if (!WDATA[CMF_RQ_LOST]) begin
                  s_nxt.rxlost = 1'b0;
               end
            end
            CMF_TQP_OFS: begin
               if (wv == CMF_PTR_ADV && qmode && s_r.txen && s_r.tc != CMF_Q_DEPTH) begin
                  s_nxt.twp = s_r.twp + 2'h1;
                  s_nxt.tc  = s_r.tc + 3'h1;
               end
            end
            CMF_RQP_OFS: begin
               if (wv == CMF_PTR_ADV && qmode && s_r.rc != 3'h0) begin
                  s_nxt.rrp = s_r.rrp + 2'h1;
                  s_nxt.rc  = s_r.rc - 3'h1;
               end
            end
            CMF_MSKA_OFS: s_nxt.mska = WDATA[28:0];
            CMF_MSKB_OFS: s_nxt.mskb = WDATA[28:0];
            CMF_CMPA_OFS: s_nxt.cmpa = WDATA[28:0];
            CMF_CMPB_OFS: s_nxt.cmpb = WDATA[28:0];
            CMF_SMOD_OFS: s_nxt.smode = WDATA[1:0];
            CMF_CSRC_OFS: s_nxt.chan = wv;
            // the transmit window fills the entry under the write pointer
            CMF_WID_OFS: begin
               if (qmode && s_r.tc != CMF_Q_DEPTH) begin
                  s_nxt.txq[s_r.twp].id = WDATA[28:0];
               end
            end
            CMF_WLO_OFS: begin
               if (qmode && s_r.tc != CMF_Q_DEPTH) begin
                  s_nxt.txq[s_r.twp].data[31:0] = WDATA;
               end
            end
            CMF_WHI_OFS: begin
               if (qmode && s_r.tc != CMF_Q_DEPTH) begin
                  s_nxt.txq[s_r.twp].data[63:32] = WDATA;
               end
            end
            default: begin
               // queue mailboxes ignore their own control registers
               if (ADDR[CMF_MCTL_BIT] && !(qmode && wj[4:3] == 2'b11)) begin
                  // flags only clear on zero, a one leaves them alone
                  for (int b = 0; b < 4; b++) begin
                     s_nxt.mctl[wj][b] = s_r.mctl[wj][b] & wv[b];
                  end
                  s_nxt.mctl[wj][4]          = wv[4];
                  s_nxt.mctl[wj][CMF_MC_ONE] = wv[CMF_MC_ONE];
                  s_nxt.mctl[wj][CMF_MC_RXS] = wv[CMF_MC_RXS];
                  s_nxt.mctl[wj][CMF_MC_TXS] = wv[CMF_MC_TXS];
                  // set bit stays readable as one until the abort is done
                  if (s_r.mctl[wj][CMF_MC_RXS] && !wv[CMF_MC_RXS] &&
                      !wv[CMF_MC_NEWD] && !wv[CMF_MC_LOST]) begin
                     s_nxt.abort[wj]             = 1'b1;
                     s_nxt.mctl[wj][CMF_MC_RXS]  = 1'b1;
                  end
               end
            end
         endcase
      end

      // reception into a normal mailbox; lower numbers win over the queue
      if (norm_ok) begin
         if (!s_r.mctl[RX_MBX][CMF_MC_NEWD]) begin
            s_nxt.mctl[RX_MBX][CMF_MC_NEWD] = 1'b1;
         end else if (!s_r.mctl[RX_MBX][CMF_MC_ONE]) begin
            s_nxt.mctl[RX_MBX][CMF_MC_LOST] = 1'b1;
         end else begin
            // one-shot holds its message regardless of lost mode
            s_nxt.mctl[RX_MBX][CMF_MC_NEWD] = 1'b1;
         end
      end else if (RX_VALID && qmode && s_r.rxen && q_match) begin
         if (s_r.rc == CMF_Q_DEPTH) begin
            s_nxt.rxlost = 1'b1;
            if (!s_r.ctl[CMF_CTL_MLM]) begin
               // overwrite the oldest and drag the read pointer along
               s_nxt.rxq[s_r.rwp] = RX_MSG;
               s_nxt.rwp = s_r.rwp + 2'h1;
               s_nxt.rrp = s_r.rrp + 2'h1;
            end
            // overrun leaves every entry, including the one being read
         end else begin
            s_nxt.rxq[s_r.rwp] = RX_MSG;
            s_nxt.rwp = s_r.rwp + 2'h1;
            s_nxt.rc  = s_nxt.rc + 3'h1;
            // warning interrupt only on a fill from two to three; a pop in the
            // same cycle keeps the count at two, so no warning is reached then
            s_nxt.rirq = s_r.ier[CMF_IE_RXQ] &&
                         (!s_r.ier[CMF_IE_RXM] ||
                          (s_r.rc == CMF_Q_WARN - 3'h1 && s_nxt.rc == CMF_Q_WARN));
         end
      end

      // transmit queue completion pops the head
      if (TXQ_DONE && s_r.tc != 3'h0) begin
         s_nxt.trp = s_r.trp + 2'h1;
         s_nxt.tc  = s_nxt.tc - 3'h1;
         s_nxt.tirq = s_r.ier[CMF_IE_TXQ] &&
                      (!s_r.ier[CMF_IE_TXM] || s_nxt.tc == 3'h0);
      end

      // a disabled queue is flushed at the next end event or when idle
      if (!s_r.txen && (TXQ_DONE || TXQ_FAIL || HALT_ENTRY || !TXQ_BUSY)) begin
         s_nxt.tc  = 3'h0;
         s_nxt.trp = s_nxt.twp;
      end

      // head offered to the engine only while the queue is running
      s_nxt.txv = s_nxt.ctl[CMF_CTL_MBM] && s_nxt.txen && s_nxt.tc != 3'h0;
      s_nxt.txo = s_nxt.txq[s_nxt.trp];
   end

   // single state register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register
   assign RDATA     = s_r.rdata;
   assign TXQ_VALID = s_r.txv;
   assign TXQ_MSG   = s_r.txo;
   assign TXQ_IRQ   = s_r.tirq;
   assign RXQ_IRQ   = s_r.rirq;

   default clocking cmf_cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   // abort request followed by the set bit dropping
   sequence abort_wr_s;
      WR && ADDR[CMF_MCTL_BIT] && !(qmode && wj[4:3] == 2'b11) &&
      s_r.mctl[wj][CMF_MC_RXS] && !wv[CMF_MC_RXS] && !wv[CMF_MC_NEWD] && !wv[CMF_MC_LOST];
   endsequence
   // j and k name the same mailbox, seen one and two cycles after the write
   sequence abort_done_s(logic [4:0] j, logic [4:0] k);
      s_r.abort[j] && s_r.mctl[j][CMF_MC_RXS] ##1 !s_r.abort[k] && !s_r.mctl[k][CMF_MC_RXS];
   endsequence

   single_try_enable_hold_a: assert property (norm_ok && !WR && s_r.mctl[RX_MBX][CMF_MC_ONE] &&
      s_r.mctl[RX_MBX][CMF_MC_NEWD] |=> s_r.mctl[$past(RX_MBX)] == $past(s_r.mctl[RX_MBX]))
      else $error("one-shot mailbox changed while holding a message");
   rx_abort_a: assert property (abort_wr_s |=> abort_done_s($past(wj), $past(wj, 2)))
      else $error("receive abort did not complete");
   rxq_ptr_adv_a: assert property (WR && ADDR == CMF_RQP_OFS && wv == CMF_PTR_ADV && qmode &&
      s_r.rc != 3'h0 && !RX_VALID |=> s_r.rrp == $past(s_r.rrp) + 2'h1 &&
      s_r.rc == $past(s_r.rc) - 3'h1)
      else $error("receive pointer did not advance");
   txq_full_a: assert property (RD && ADDR == CMF_TQC_OFS |=>
      RDATA[CMF_TQ_FUL] == ($past(s_r.tc) == CMF_Q_DEPTH) &&
      RDATA[CMF_TQ_EMP] == ($past(s_r.tc) == 3'h0))
      else $error("transmit queue status wrong");
   rxq_overrun_a: assert property (RX_VALID && !norm_ok && qmode && s_r.rxen && q_match &&
      s_r.rc == CMF_Q_DEPTH && s_r.ctl[CMF_CTL_MLM] && !(WR && ADDR == CMF_RQP_OFS) |=>
      s_r.rxlost && $stable(s_r.rxq) && $stable(s_r.rrp))
      else $error("overrun altered the receive queue");
   rxq_warn_irq_a: assert property (RXQ_IRQ && $past(s_r.ier[CMF_IE_RXM]) |->
      s_r.rc == CMF_Q_WARN && $past(s_r.rc) == CMF_Q_WARN - 3'h1)
      else $error("warning interrupt without a fill to three");
   txq_halt_a: assert property (!s_r.txen |-> !TXQ_VALID)
      else $error("disabled transmit queue offered a message");
   txq_abort_a: assert property (!s_r.txen && !TXQ_BUSY && !WR |=> s_r.tc == 3'h0)
      else $error("transmit abort did not empty the queue");
   rx_search_a: assert property (RD && ADDR == CMF_SSTA_OFS && qmode &&
      s_r.smode == CMF_SM_RX && s_r.rc != 3'h0 && cand[23:0] == 24'h0 |=>
      RDATA[4:0] == CMF_RXQ_MBX && !RDATA[CMF_SS_NONE])
      else $error("receive search missed the queue window");

endmodule : cmf_top
`default_nettype wire

// file: bench/cmf_engine.sv
`timescale 1ns/10ps
`default_nettype none
module cmf_engine
   import cmf_pkg::*;
(
   // clock and queue head
   input  wire logic  clk,
   input  wire logic  tx_go,
   input  wire logic  txq_valid,
   // receive delivery
   output logic       rx_valid,
   output cmf_msg_t   rx_msg,
   output logic       rx_hit,
   output logic [4:0] rx_mbx,
   // transmit handshake
   output logic       txq_busy,
   output logic       txq_done
);
   initial begin
      rx_valid = 1'b0;
      rx_msg   = '0;
      rx_hit   = 1'b0;
      rx_mbx   = 5'h00;
      txq_busy = 1'b0;
      txq_done = 1'b0;
   end
   // one whole frame per pulse; lines turn to junk outside it
   task automatic send(input logic [28:0] id, input logic hit, input logic [4:0] mbx);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_msg   <= '{id: id, data: {35'h0, id}};
      rx_hit   <= hit;
      rx_mbx   <= mbx;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_msg   <= ~rx_msg;
      rx_hit   <= ~hit;
      rx_mbx   <= ~mbx;
   endtask : send
   // slow sender; head and count update together a cycle after done, so it pauses before looking again
   always begin
      @(posedge clk);
      if (tx_go && txq_valid) begin
         txq_busy <= 1'b1;
         repeat (3) @(posedge clk);
         txq_done <= 1'b1;
         txq_busy <= 1'b0;
         @(posedge clk);
         txq_done <= 1'b0;
         repeat (2) @(posedge clk);
      end
   end
endmodule : cmf_engine
`default_nettype wire

// file: bench/cmf_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module cmf_top_test;
   import cmf_pkg::*;
   logic        clk, rst, wr, rd, tx_go, rxv, hit, busy, done, txv, rirq, tirq;
   logic [7:0]  addr;
   logic [4:0]  mbx;
   logic [31:0] wdata, rdata;
   cmf_msg_t    rmsg, tmsg;
   int          mismatches, num_checks, rx_irqs, tx_irqs, txn;
   cmf_top u_dut (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .RX_VALID(rxv), .RX_MSG(rmsg), .RX_MBX_HIT(hit), .RX_MBX(mbx),
      .TXQ_BUSY(busy), .TXQ_DONE(done), .TXQ_FAIL(1'b0), .HALT_ENTRY(1'b0),
      .TXQ_VALID(txv), .TXQ_MSG(tmsg), .TXQ_IRQ(tirq), .RXQ_IRQ(rirq));
   cmf_engine u_eng (.clk(clk), .tx_go(tx_go), .txq_valid(txv), .rx_valid(rxv), .rx_msg(rmsg),
      .rx_hit(hit), .rx_mbx(mbx), .txq_busy(busy), .txq_done(done));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rdc
   // pulse counters and in-order check of transmitted heads
   always @(posedge clk) begin
      if (rirq === 1'b1) rx_irqs++;
      if (tirq === 1'b1) tx_irqs++;
      if (done === 1'b1) begin
         chk({3'h0, tmsg.id}, 32'h100 + txn);
         txn++;
      end
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic t_reset;
      rdc(CMF_TQC_OFS, 32'h2);
      rdc(CMF_RQC_OFS, 32'h4);
      rdc(8'h3C, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_rxq;
      wrr(CMF_CTL_OFS, 32'h1);
      wrr(CMF_RQC_OFS, 32'h1);
      wrr(CMF_IER_OFS, 32'h3000_0000);
      wrr(CMF_MSKA_OFS, 32'h1FFF_FF00);
      wrr(CMF_CMPA_OFS, 32'h100);
      wrr(CMF_MSKB_OFS, 32'h1FFF_FFFF);
      wrr(CMF_CMPB_OFS, 32'h456);
      u_eng.send(29'h7, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h5);
      for (int i = 0; i < 3; i++) u_eng.send(29'h100 + i, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h9);
      u_eng.send(29'h103, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h11);
      u_eng.send(29'h104, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h13);
      rdc(CMF_WID_OFS, 32'h101);
      rdc(CMF_RQC_OFS, 32'h13);
      wrr(CMF_RQP_OFS, 32'hFF);
      rdc(CMF_WID_OFS, 32'h102);
      rdc(CMF_WLO_OFS, 32'h102);
      chk(rx_irqs, 1);
      wrr(CMF_SMOD_OFS, 32'h0);
      rdc(CMF_SSTA_OFS, 32'h1C);
      // overrun: clear lost, refill to full, then one more must be dropped
      wrr(CMF_CTL_OFS, 32'h3);
      wrr(CMF_RQC_OFS, 32'h1);
      u_eng.send(29'h105, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h11);
      u_eng.send(29'h106, 1'b0, 5'h0);
      rdc(CMF_RQC_OFS, 32'h13);
      rdc(CMF_WID_OFS, 32'h102);
      chk(rx_irqs, 1);
      $display("receive queue test done");
   endtask : t_rxq
   task automatic t_single_try_enable;
      wrr(8'hE0, 32'h60);
      rdc(8'hE0, 32'h0);
      wrr(8'h8C, 32'h60);
      u_eng.send(29'h33, 1'b1, 5'd3);
      rdc(8'h8C, 32'h61);
      u_eng.send(29'h34, 1'b1, 5'd3);
      rdc(8'h8C, 32'h61);
      wrr(8'h8C, 32'h3C);
      rdc(8'h8C, 32'h30);
      wrr(8'h8C, 32'h10);
      rdc(8'h8C, 32'h10);
      wrr(8'h8C, 32'h0);
      wrr(8'h8C, 32'h40);
      u_eng.send(29'h35, 1'b1, 5'd3);
      u_eng.send(29'h36, 1'b1, 5'd3);
      rdc(8'h8C, 32'h43);
      rdc(CMF_SSTA_OFS, 32'h3);
      $display("single try test done");
   endtask : t_single_try_enable
   task automatic txc(input int i);
      wrr(CMF_WID_OFS, 32'h100 + i);
      wrr(CMF_WLO_OFS, i);
      wrr(CMF_WHI_OFS, 32'h0);
      wrr(CMF_TQP_OFS, 32'hFF);
   endtask : txc
   task automatic t_txq;
      wrr(CMF_IER_OFS, 32'h0100_0000);
      wrr(CMF_TQC_OFS, 32'h1);
      txc(0);
      txc(1);
      wrr(CMF_TQC_OFS, 32'h0);
      rdc(CMF_TQC_OFS, 32'h2);
      chk(txv, 1'b0);
      wrr(CMF_TQC_OFS, 32'h1);
      for (int i = 0; i < 4; i++) txc(i);
      rdc(CMF_TQC_OFS, 32'h5);
      chk(txv, 1'b1);
      tx_go <= 1'b1;
      for (int i = 0; i < 200 && txn < 4; i++) @(posedge clk);
      // a stalled engine counts once and the run goes on to the report
      if (txn < 4) mismatches++;
      rdc(CMF_TQC_OFS, 32'h3);
      chk(tx_irqs, 4);
      $display("transmit queue test done");
   endtask : t_txq
   initial begin
      rst   = 1'b1;
      wr    = 1'b0;
      rd    = 1'b0;
      tx_go = 1'b0;
      addr  = 8'h00;
      wdata = 32'h0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_rxq();
      t_single_try_enable();
      t_txq();
      end_sim();
   end
endmodule : cmf_top_test
`default_nettype wire
